// ### hw/pattern_readout_params.svh
// Constants for the pattern register readout block
`ifndef PATTERN_READOUT_PARAMS_SVH
`define PATTERN_READOUT_PARAMS_SVH
`define MR3_PAGE_LSB 0
`define MR3_ENABLE_BIT 2
`define MR3_TEMP_EN_BIT 5
`define MR3_FMT_LSB 11
`define MR5_PARLAT_LSB 0
`define PAGE2_LOC0_OFFSET 2'h0
`define PAGE2_LOC1_OFFSET 2'h1
`define PAGE2_LOC2_OFFSET 2'h2
`define PAGE2_LOC3_OFFSET 2'h3
`define TEMP_FIELD_LSB 3
`define TEMP_MAX_AGE_MS 32
`define CLK_FREQ_KHZ 25000
`define TEMP_REFRESH_CYCLES (`TEMP_MAX_AGE_MS * `CLK_FREQ_KHZ)
`endif

// ### hw/pattern_readout_pkg.sv
// Types for the pattern register readout block
package pattern_readout_pkg;
   typedef enum logic [1:0] {
      FMT_SERIAL = 2'h0,
      FMT_PARALLEL = 2'h1,
      FMT_STAGGERED = 2'h2,
      FMT_RESERVED = 2'h3
   } read_format_t;
   typedef enum logic [1:0] {
      TEMP_SUB_1X = 2'h0,
      TEMP_1X = 2'h1,
      TEMP_2X = 2'h2,
      TEMP_RSVD = 2'h3
   } temp_status_t;
   typedef struct packed {
      logic valid;
      logic read_autoprecharge;
      logic [1:0] bank_addr;
      logic burst_order_bit;
      logic burst_chop;
   } read_cmd_t;
   typedef struct packed {
      logic valid;
      logic strobe_en;
      logic [7:0] dq;
   } read_beat_t;
endpackage : pattern_readout_pkg

// ### hw/pattern_readout.sv
// Pattern register readout path of the memory device
//
// Contract
// - Page 1 parity error log visible only while mode register three enable is set.
// - Page 1 location 3 bits 2:0 show latest programmed parity latency.
// - Page 2 returns mode register contents at locations 0 to 3.
// - Temperature status sits in page 2 location 0 bits 4:3.
// - With temperature readout enabled, status refreshed at most 32 ms old.
// - With temperature readout disabled, status bits stop updating.
// - Strobes driven with pattern data, read preamble honoured.
// - Mode register three bits 1:0 select pattern page 0 to 3.
// - Bank address bits 1:0 select pattern location 0 to 3.
// - Address bit 2 selects burst order, beats 0 first or 4 first.
// - Data burst after additive plus read latency, format per page and field.
// - Serial format drives the same pattern on every lane.
// - Parallel format drives one location 0 bit per lane each beat.
// - Staggered format rotates locations across lanes, upper nibble mirrors lower.
`include "pattern_readout_params.svh"
`timescale 1ns/10ps
`default_nettype none
module pattern_readout #(
   parameter int unsigned MAX_LATENCY = 32,
   parameter int unsigned TEMP_REFRESH = `TEMP_REFRESH_CYCLES
) (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic [13:0] mode_reg_zero,
   input wire logic [13:0] mode_reg_one,
   input wire logic [13:0] mode_reg_two,
   input wire logic [13:0] mode_reg_three,
   input wire logic [13:0] mode_reg_five,
   input wire logic [13:0] mode_reg_six,
   input wire logic [4:0] additive_latency,
   input wire logic [4:0] read_cas_latency,
   input wire logic read_preamble_2t,
   input wire logic [7:0] error_log_loc0,
   input wire logic [7:0] error_log_loc1,
   input wire logic [7:0] error_log_loc2,
   input wire logic [4:0] error_log_loc3_hi,
   input wire logic [7:0] page0_loc0,
   input wire logic [7:0] page0_loc1,
   input wire logic [7:0] page0_loc2,
   input wire logic [7:0] page0_loc3,
   input wire pattern_readout_pkg::temp_status_t sensor_temp,
   input wire pattern_readout_pkg::read_cmd_t read_cmd,
   output logic array_read,
   output pattern_readout_pkg::read_beat_t read_beat,
   output logic strobe_preamble
);
   import pattern_readout_pkg::*;

   localparam int unsigned LAT_W = $clog2(MAX_LATENCY + 1);
   localparam int unsigned TMR_W = $clog2(TEMP_REFRESH + 1);

   function automatic logic [7:0] loc_data(input logic [1:0] page,
                                           input logic [1:0] loc,
                                           input logic [31:0] p0,
                                           input logic [31:0] p1,
                                           input logic [31:0] p2);
      logic [31:0] sel;
      sel = 32'h0;
      unique case (page)
         2'h0: sel = p0;
         2'h1: sel = p1;
         2'h2: sel = p2;
         2'h3: sel = 32'h0;
      endcase
      loc_data = sel[8*loc +: 8];
   endfunction : loc_data

   wire logic readout_en = mode_reg_three[`MR3_ENABLE_BIT];
   wire logic [1:0] page = mode_reg_three[`MR3_PAGE_LSB +: 2];
   wire read_format_t fmt =
      read_format_t'(mode_reg_three[`MR3_FMT_LSB +: 2]);
   wire logic temp_en = mode_reg_three[`MR3_TEMP_EN_BIT];

   // Temperature status latch and refresh timer
   logic [1:0] temp_q;
   logic [1:0] temp_d;
   logic [TMR_W-1:0] tmr_q;
   logic [TMR_W-1:0] tmr_d;
   wire logic tmr_done = (tmr_q == TMR_W'(TEMP_REFRESH - 1));
   // Sample on the last and first count of each refresh period, just inside the age limit; frozen while disabled
   assign tmr_d = (!temp_en || tmr_done) ? '0 : tmr_q + 1'b1;
   assign temp_d = (temp_en && (tmr_done || !(|tmr_q))) ?
                   sensor_temp : temp_q;

   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         temp_q <= 2'h0;
         tmr_q <= '0;
      end else begin
         temp_q <= temp_d;
         tmr_q <= tmr_d;
      end
   end

   // Page images, locations packed low to high
   wire logic [7:0] p2_loc0 = {2'h0, 1'b0, temp_q, mode_reg_two[12],
                               mode_reg_two[10:9]};
   wire logic [7:0] p2_loc1 = {mode_reg_six[6:0], mode_reg_three[3]};
   wire logic [7:0] p2_loc2 = {mode_reg_zero[6:4], mode_reg_zero[2], 1'b0,
                               mode_reg_two[5:3]};
   wire logic [7:0] p2_loc3 = {mode_reg_one[10:8], mode_reg_five[8:6],
                               mode_reg_one[2:1]};
   wire logic [7:0] p1_loc3 = {error_log_loc3_hi,
                               mode_reg_five[`MR5_PARLAT_LSB +: 3]};
   wire logic [31:0] page0_img = {page0_loc3, page0_loc2, page0_loc1,
                                  page0_loc0};
   // Log hidden unless the mode register three readout enable is set
   wire logic [31:0] page1_img = readout_en ? {p1_loc3, error_log_loc2,
                                 error_log_loc1, error_log_loc0} : 32'h0;
   wire logic [31:0] page2_img = {p2_loc3, p2_loc2, p2_loc1, p2_loc0};

   // Build the 8 beats x 8 lanes of one burst at command time
   logic [63:0] burst_img;
   genvar b;
   genvar l;
   generate
      for (b = 0; b < 8; b++) begin : g_beat
         for (l = 0; l < 8; l++) begin : g_lane
            wire logic [1:0] sloc = read_cmd.bank_addr + 2'(l % 4);
            wire logic [7:0] ser = loc_data(page, read_cmd.bank_addr,
                                            page0_img, page1_img, page2_img);
            wire logic [7:0] stg = loc_data(page, sloc, page0_img,
                                            page1_img, page2_img);
            wire logic [7:0] par = loc_data(page, 2'h0, page0_img,
                                            page1_img, page2_img);
            // Serial and staggered: beat b carries bit 7-b of the location (first beat is MSB)
            assign burst_img[8*b + l] =
               (fmt == FMT_PARALLEL && page == 2'h0) ? par[7-l] :
               (fmt == FMT_STAGGERED && page == 2'h0) ? stg[7-b] :
               ser[7-b];
         end
      end
   endgenerate

   // Latency pipeline: each command with rl from 1 to MAX_LATENCY launches its own burst image; others launch none
   wire logic [LAT_W-1:0] rl = LAT_W'(additive_latency) +
                               LAT_W'(read_cas_latency);
   wire logic take = read_cmd.valid && readout_en;
   assign array_read = read_cmd.valid && !readout_en;

   logic [MAX_LATENCY-1:0] launch_q;
   logic [63:0] img_q [MAX_LATENCY];
   logic [MAX_LATENCY-1:0] chop_q;
   logic [MAX_LATENCY-1:0] ord_q;
   logic [2:0] beat_q;
   logic [2:0] beat_d;
   logic busy_q;
   logic busy_d;
   logic [63:0] cur_q;
   logic cur_chop_q;
   logic cur_ord_q;
   wire logic start = launch_q[0];
   // Order 4-first rotates beats; chop stops after four
   wire logic [2:0] ubeat = beat_q ^ {cur_ord_q, 2'h0};
   wire logic last = cur_chop_q ? (beat_q == 3'h3) : (beat_q == 3'h7);
   assign busy_d = start ? 1'b1 : (busy_q && !last);
   assign beat_d = start ? 3'h0 : (busy_q ? beat_q + 3'h1 : beat_q);

   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         launch_q <= '0;
         chop_q <= '0;
         ord_q <= '0;
         busy_q <= 1'b0;
         beat_q <= 3'h0;
         cur_q <= 64'h0;
         cur_chop_q <= 1'b0;
         cur_ord_q <= 1'b0;
         read_beat <= '0;
         strobe_preamble <= 1'b0;
      end else begin
         launch_q <= launch_q >> 1;
         chop_q <= chop_q >> 1;
         ord_q <= ord_q >> 1;
         if (take && rl != '0) begin
            launch_q[rl-1] <= 1'b1;
            chop_q[rl-1] <= read_cmd.burst_chop;
            ord_q[rl-1] <= read_cmd.burst_order_bit;
         end
         busy_q <= busy_d;
         beat_q <= beat_d;
         if (start) begin
            cur_q <= img_q[0];
            cur_chop_q <= chop_q[0];
            cur_ord_q <= ord_q[0];
         end
         read_beat.valid <= busy_q;
         read_beat.strobe_en <= busy_q;
         read_beat.dq <= busy_q ? cur_q[8*ubeat +: 8] : 8'h0;
         // Extra strobe cycle ahead of the burst in 2T mode
         strobe_preamble <= read_preamble_2t ? (launch_q[1] || start)
                                             : start;
      end
   end

   genvar s;
   generate
      for (s = 0; s < MAX_LATENCY; s++) begin : g_img
         always_ff @(posedge clk_sys) begin
            if (!nrst) begin
               img_q[s] <= 64'h0;
            end else if (take && rl != '0 && s == int'(rl) - 1) begin
               img_q[s] <= burst_img;
            end else if (s < MAX_LATENCY - 1) begin
               img_q[s] <= img_q[(s + 1) % MAX_LATENCY];
            end else begin
               img_q[s] <= 64'h0;
            end
         end
      end
   endgenerate
endmodule : pattern_readout
`default_nettype wire

// ### verification/pattern_readout_checker.sv
// Port assertions for the pattern readout block
`timescale 1ns/10ps
`default_nettype none
module pattern_readout_checker (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic [13:0] mode_reg_three,
   input wire pattern_readout_pkg::read_cmd_t read_cmd,
   input wire logic array_read,
   input wire pattern_readout_pkg::read_beat_t read_beat,
   input wire logic strobe_preamble
);
   import pattern_readout_pkg::*;
   wire logic en = mode_reg_three[2];
   wire logic bv = read_beat.valid;
   wire logic [1:0] fm = mode_reg_three[12:11];
   wire logic pg0 = mode_reg_three[1:0] == 2'h0;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   property p_arr; read_cmd.valid && !en |-> array_read; endproperty
   a_arr: assert property (p_arr) else $error("array read missing");
   property p_noarr; read_cmd.valid && en |-> !array_read; endproperty
   a_noarr: assert property (p_noarr) else $error("array read seen");
   property p_stb; bv |-> read_beat.strobe_en; endproperty
   a_stb: assert property (p_stb) else $error("strobe off");
   property p_pre; $rose(bv) |-> $past(strobe_preamble); endproperty
   a_pre: assert property (p_pre) else $error("no preamble");
   property p_len; $rose(bv) |-> bv [*4]; endproperty
   a_len: assert property (p_len) else $error("short burst");
   property p_ser; bv && fm == 2'h0 |-> read_beat.dq inside {8'h00, 8'hFF};
   endproperty
   a_ser: assert property (p_ser) else $error("lanes differ");
   property p_par; bv && $past(bv) && fm == 2'h1 && pg0 |->
      $stable(read_beat.dq); endproperty
   a_par: assert property (p_par) else $error("beat changed");
   property p_stg; bv && fm == 2'h2 && pg0 |->
      read_beat.dq[7:4] == read_beat.dq[3:0]; endproperty
   a_stg: assert property (p_stg) else $error("nibbles differ");
endmodule : pattern_readout_checker
bind pattern_readout pattern_readout_checker u_chk (.clk_sys, .nrst,
   .mode_reg_three, .read_cmd, .array_read, .read_beat, .strobe_preamble);
`default_nettype wire

// ### verification/pattern_ctrl_model.sv
// Memory controller model issuing spaced pattern reads
`timescale 1ns/10ps
`default_nettype none
module pattern_ctrl_model (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic go,
   input wire logic [2:0] req,
   input wire logic chop,
   output pattern_readout_pkg::read_cmd_t read_cmd,
   output logic busy
);
   import pattern_readout_pkg::*;
   logic [3:0] gap_q;
   assign busy = gap_q != 4'h0;
   always_ff @(posedge clk_sys) begin
      read_cmd <= '0;
      if (!nrst) begin
         gap_q <= 4'h0;
      end else if (busy) begin
         gap_q <= gap_q - 4'h1;
      end else if (go) begin
         // Burst-length spacing, never tighter than a burst
         gap_q <= chop ? 4'h3 : 4'h7;
         read_cmd <= '{1'b1, 1'b0, req[1:0], req[2], chop};
      end
   end
endmodule : pattern_ctrl_model
`default_nettype wire

// ### verification/pattern_readout_tb_top.sv
// Self-checking bench for the pattern readout block
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, a, e) begin checks++; if ((a) !== (e)) begin err_total++; \
   $display("unexpected %s exp %h got %h", n, e, a); end end
module pattern_readout_tb_top;
   import pattern_readout_pkg::*;
   logic clk_sys, nrst, go, chop, read_preamble_2t, array_read, busy, hit;
   logic strobe_preamble;
   logic [2:0] req;
   logic [1:0] exp_temp;
   logic [4:0] additive_latency, read_cas_latency, error_log_loc3_hi;
   logic [13:0] mode_reg_zero, mode_reg_one, mode_reg_two, mode_reg_three;
   logic [13:0] mode_reg_five, mode_reg_six;
   logic [7:0] error_log_loc0, error_log_loc1, error_log_loc2;
   logic [7:0] page0_loc0, page0_loc1, page0_loc2, page0_loc3;
   temp_status_t sensor_temp;
   read_cmd_t read_cmd;
   read_beat_t read_beat;
   int seed = 69622;
   int cyc = 0, rl = 0, checks = 0, err_total = 0;
   typedef struct {int c; logic [7:0] d;} beat_t;
   beat_t q[$];
   // Short temperature refresh keeps the run brief
   pattern_readout #(.TEMP_REFRESH(16)) u_dut (.*);
   pattern_ctrl_model u_ctrl (.*);
   always #20 clk_sys = ~clk_sys;
   function automatic logic [7:0] img(input logic [1:0] p, input logic [1:0] l);
      logic [7:0] t [16];
      // Log bits the controller treats as don't care are still compared
      t = '{page0_loc0, page0_loc1, page0_loc2, page0_loc3, error_log_loc0,
         error_log_loc1, error_log_loc2,
         {error_log_loc3_hi, mode_reg_five[2:0]},
         {3'h0, exp_temp, mode_reg_two[12], mode_reg_two[10:9]},
         {mode_reg_six[6:0], mode_reg_three[3]},
         {mode_reg_zero[6:4], mode_reg_zero[2], 1'b0, mode_reg_two[5:3]},
         {mode_reg_one[10:8], mode_reg_five[8:6], mode_reg_one[2:1]},
         8'h00, 8'h00, 8'h00, 8'h00};
      return t[{p, l}];
   endfunction : img
   function automatic logic [7:0] exp_dq(input logic [1:0] a, input logic o,
      input int k);
      logic [7:0] d;
      logic [7:0] w;
      logic [1:0] f;
      int b;
      f = mode_reg_three[1:0] == 2'h0 ? mode_reg_three[12:11] : 2'h0;
      b = o ? (k + 4) % 8 : k;
      for (int l = 0; l < 8; l++) begin
         w = img(mode_reg_three[1:0], f == 2'h2 ? a + 2'(l) : a);
         d[l] = w[f == 2'h1 ? 7 - l : 7 - b];
      end
      return d;
   endfunction : exp_dq
   task automatic rnd;
      {page0_loc0, page0_loc1, page0_loc2, page0_loc3} = $random(seed);
      {error_log_loc0, error_log_loc1, error_log_loc2, error_log_loc3_hi} =
         29'($random(seed));
      {mode_reg_zero, mode_reg_one} = 28'($random(seed));
      {mode_reg_two, mode_reg_five} = 28'($random(seed));
      mode_reg_six = 14'($random(seed));
      additive_latency = 5'($random(seed)) & 5'h03;
      read_cas_latency = 5'h05 + (5'($random(seed)) & 5'h07);
      read_preamble_2t = 1'($random(seed));
      rl = additive_latency + read_cas_latency;
   endtask : rnd
   task automatic rd(input logic [2:0] r, input logic c);
      @(posedge clk_sys);
      #1;
      while (busy) begin
         @(posedge clk_sys);
         #1;
      end
      go = 1'b1;
      req = r;
      chop = c;
      @(posedge clk_sys);
      #1;
      go = 1'b0;
   endtask : rd
   task automatic drain;
      while (busy || q.size() != 0) begin
         @(posedge clk_sys);
         #1;
      end
   endtask : drain
   task automatic report_and_stop;
      $display("checks %0d errors %0d", checks, err_total);
      if (err_total == 0 && checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : report_and_stop
   always @(posedge clk_sys) begin
      #2;
      cyc++;
      hit = q.size() != 0 && q[0].c == cyc;
      `CHK("beat valid", read_beat.valid, hit)
      if (hit) begin
         `CHK("beat data", read_beat.dq, q[0].d)
         void'(q.pop_front());
      end
      if (read_cmd.valid === 1'b1 && mode_reg_three[2])
         for (int k = 0; k < (read_cmd.burst_chop ? 4 : 8); k++)
            q.push_back('{cyc + rl + 2 + k, exp_dq(read_cmd.bank_addr,
               read_cmd.burst_order_bit, k)});
   end
   always @(posedge clk_sys) if (cyc == 6000) begin
      err_total++;
      report_and_stop;
   end
   initial begin
      clk_sys = 1'b0;
      {nrst, go, chop, req, exp_temp} = '0;
      rnd;
      mode_reg_three = 14'h0000;
      sensor_temp = TEMP_SUB_1X;
      repeat (4) @(posedge clk_sys);
      #1;
      nrst = 1'b1;
      for (int t = 0; t < 4; t++) begin
         sensor_temp = temp_status_t'(t);
         exp_temp = 2'(t);
         mode_reg_three = 14'h0026;
         repeat (20) @(posedge clk_sys);
         rd(3'h0, 1'b0);
         drain;
      end
      // Readout stays enabled, temperature updates stop
      mode_reg_three = 14'h0006;
      sensor_temp = TEMP_1X;
      repeat (40) @(posedge clk_sys);
      rd(3'h4, 1'b1);
      drain;
      for (int p = 0; p < 4; p++)
         for (int f = 0; f < 3; f++) if (p == 0 || f == 0) begin
            rnd;
            mode_reg_three = {1'b0, 2'(f), 8'h00, 1'b1, 2'(p)};
            for (int n = 0; n < 8; n++)
               rd({1'($random(seed)), (f == 1 ? 2'h0 : 2'($random(seed)))},
                  (mode_reg_zero[1:0] == 2'h1) ? 1'b0 :
                  1'($random(seed)));
            drain;
         end
      repeat (8) @(posedge clk_sys);
      #1;
      mode_reg_three = 14'h0000;
      repeat (8) @(posedge clk_sys);
      rd(3'h1, 1'b0);
      drain;
      report_and_stop;
   end
endmodule : pattern_readout_tb_top
`default_nettype wire
